// file: hdl/tim_mask_top.sv
// module: timer interrupt mask register with apb slave and interrupt output
`timescale 1ns/100ps
module tim_mask_top
    import tim_pkg::*;
(
    // apb clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [TIM_ADDR_W-1:0] paddr,
    input  wire logic [TIM_DATA_W-1:0] pwdata,
    output logic      [TIM_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // asynchronous source event levels
    input  wire logic [TIM_NSRC-1:0]   src_event,
    // controller-level interrupt
    output logic                       irq
);
    import tim_pkg::*;

    tim_status_if st ();

    logic [TIM_NSRC-1:0]   timer_interrupt_mask_q;
    logic [TIM_NSRC-1:0]   sync1_q;
    logic [TIM_NSRC-1:0]   sync2_q;
    logic [TIM_NSRC-1:0]   sync3_q;
    logic [TIM_NSRC-1:0]   clear_pulse;
    logic [TIM_DATA_W-1:0] prdata_q;
    logic                  pready_q;
    logic                  pslverr_q;
    logic                  wr_hit;
    logic                  rd_hit;
    logic                  setup;

    // decode of implemented word addresses
    function automatic logic addr_known(input logic [TIM_ADDR_W-1:0] a);
        return (a == TIM_OFS_MASK) || (a == TIM_OFS_RAW) || (a == TIM_OFS_MSTAT) || (a == TIM_OFS_CLEAR);
    endfunction

    // zero-extend an 11-bit field into the read word
    function automatic logic [TIM_DATA_W-1:0] widen(input logic [TIM_NSRC-1:0] v);
        return {{(TIM_DATA_W-TIM_NSRC){1'b0}}, v};
    endfunction

    // setup phase answered one cycle later, access completes with pready
    assign setup  = psel && !penable;
    assign wr_hit = psel && penable && pready_q && pwrite;
    assign rd_hit = setup && !pwrite;

    // two flip-flop synchroniser and rising edge detect on the events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= src_event;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // mask register, reserved bits dropped on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_interrupt_mask_q <= TIM_MASK_RESET;
        end else if (wr_hit && paddr == TIM_OFS_MASK) begin
            timer_interrupt_mask_q <= pwdata[TIM_NSRC-1:0] & TIM_IMPL_MASK;
        end
    end

    // write-one-to-clear strobe to the status core
    assign clear_pulse = (wr_hit && paddr == TIM_OFS_CLEAR) ? pwdata[TIM_NSRC-1:0] : '0;
    assign st.mask     = timer_interrupt_mask_q;
    assign st.clear    = clear_pulse;

    tim_status_core u_core (
        .pclk        (pclk),
        .presetn     (presetn),
        .event_pulse (sync2_q & ~sync3_q),
        .st          (st.core)
    );

    // apb answer: no wait state, pready in the first access cycle, read data captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= TIM_RDATA_ZERO;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !addr_known(paddr);
            if (rd_hit) begin
                case (paddr)
                    TIM_OFS_MASK:  prdata_q <= widen(timer_interrupt_mask_q);
                    TIM_OFS_RAW:   prdata_q <= widen(st.raw);
                    TIM_OFS_MSTAT: prdata_q <= widen(st.masked);
                    default:       prdata_q <= TIM_RDATA_ZERO;
                endcase
            end else if (!setup) begin
                prdata_q <= TIM_RDATA_ZERO;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = st.irq; // flop inside core

    mask_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> timer_interrupt_mask_q == TIM_MASK_RESET)
        else $error("mask not zero after reset");
    mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_hit && paddr == TIM_OFS_MASK |=> timer_interrupt_mask_q == ($past(pwdata[10:0]) & TIM_IMPL_MASK))
        else $error("mask write not stored");
    rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn) timer_interrupt_mask_q[7:4] == 4'h0)
        else $error("reserved mask bits set");
    irq_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> $past(|(st.raw & timer_interrupt_mask_q)) || $past(|(sync2_q & ~sync3_q & timer_interrupt_mask_q)))
        else $error("irq without unmasked event");
    irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        |(st.raw & timer_interrupt_mask_q) && clear_pulse == '0 |=> irq)
        else $error("irq missing for unmasked pending bit");
    cap_b_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !timer_interrupt_mask_q[TIM_CAP_B_EVENT] |-> !st.masked[TIM_CAP_B_EVENT])
        else $error("capture B event passes closed mask");
    tmr_b_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.raw[TIM_TMR_B_TO] && timer_interrupt_mask_q[TIM_TMR_B_TO] |-> st.masked[TIM_TMR_B_TO])
        else $error("timer B timeout blocked by open mask");
    clk_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.masked[TIM_CLK_EVENT] |-> timer_interrupt_mask_q[TIM_CLK_EVENT] && st.raw[TIM_CLK_EVENT])
        else $error("clock event masked bit wrong");
    cap_a_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.masked[TIM_CAP_A_EVENT:TIM_CAP_A_MATCH] == (st.raw[2:1] & timer_interrupt_mask_q[2:1]))
        else $error("capture A gating wrong");
    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn) psel && !penable |=> pready)
        else $error("pready not one cycle after setup");
endmodule

// file: hdl/tim_pkg.sv
// package: register map, field positions and reset values of the timer interrupt mask block
package tim_pkg;
    localparam int          TIM_DATA_W       = 32;
    localparam int          TIM_ADDR_W       = 12;
    localparam int          TIM_NSRC         = 11;
    // register byte offsets
    localparam logic [11:0] TIM_OFS_MASK     = 12'h018;
    localparam logic [11:0] TIM_OFS_RAW      = 12'h01C;
    localparam logic [11:0] TIM_OFS_MSTAT    = 12'h020;
    localparam logic [11:0] TIM_OFS_CLEAR    = 12'h024;
    // mask field positions
    localparam int          TIM_TMR_A_TO     = 0;
    localparam int          TIM_CAP_A_MATCH  = 1;
    localparam int          TIM_CAP_A_EVENT  = 2;
    localparam int          TIM_CLK_EVENT    = 3;
    localparam int          TIM_TMR_B_TO     = 8;
    localparam int          TIM_CAP_B_MATCH  = 9;
    localparam int          TIM_CAP_B_EVENT  = 10;
    // implemented bits: 10..8 and 3..0, bits 7..4 reserved
    localparam logic [10:0] TIM_IMPL_MASK    = 11'h70F;
    localparam logic [10:0] TIM_MASK_RESET   = 11'h000;
    localparam logic [31:0] TIM_RDATA_ZERO   = 32'h0000_0000;
    typedef enum logic [1:0] {TIM_APB_IDLE, TIM_APB_SETUP, TIM_APB_ACCESS} tim_apb_phase_type;
endpackage

// file: hdl/tim_status_core.sv
// module: sticky raw status capture and mask gating
`timescale 1ns/100ps
module tim_status_core
    import tim_pkg::*;
(
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // synchronised source events
    input  wire logic [TIM_NSRC-1:0]  event_pulse,
    // link to the front end
    tim_status_if.core                st
);
    logic [TIM_NSRC-1:0] raw_q;
    logic [TIM_NSRC-1:0] raw_d;
    logic                irq_q;

    // sticky raw bits, set wins over write-one clear, mask not consulted
    always_comb begin
        raw_d = ((raw_q & ~st.clear) | event_pulse) & TIM_IMPL_MASK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_q <= TIM_MASK_RESET;
        end else begin
            raw_q <= raw_d;
        end
    end

    // level interrupt from any unmasked pending bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(raw_d & st.mask);
        end
    end

    assign st.raw    = raw_q;
    assign st.masked = raw_q & st.mask;
    assign st.irq    = irq_q;

    raw_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        |(event_pulse & TIM_IMPL_MASK) |=>
        ((raw_q & $past(event_pulse & TIM_IMPL_MASK)) == $past(event_pulse & TIM_IMPL_MASK)))
        else $error("raw bit not set by event");
endmodule

// file: hdl/tim_status_if.sv
// interface: raw status and mask between the register front end and the status core
`timescale 1ns/100ps
interface tim_status_if;
    logic [10:0] raw;
    logic [10:0] mask;
    logic [10:0] clear;
    logic [10:0] masked;
    logic        irq;
    modport core  (input mask, input clear, output raw, output masked, output irq);
    modport front (output mask, output clear, input raw, input masked, input irq);
endinterface

// file: tb/timer_interrupt_mask_bench.sv
// testbench: random and corner checks of the timer interrupt mask block over apb
`timescale 1ns/100ps
module timer_interrupt_mask_bench;
    import tim_pkg::*;
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [TIM_ADDR_W-1:0] paddr;
    logic [TIM_DATA_W-1:0] pwdata;
    logic [TIM_DATA_W-1:0] prdata;
    logic                  pready;
    logic                  pslverr;
    logic [TIM_NSRC-1:0]   src_event;
    logic                  irq;
    logic [31:0]           rd;
    logic                  err;
    logic [31:0]           seed = 32'h5AD4;
    logic [31:0]           m;
    logic [10:0]           ev;
    int                    fail_count = 0;
    int                    comparisons = 0;
    int                    pos [7] = '{TIM_TMR_A_TO, TIM_CAP_A_MATCH, TIM_CAP_A_EVENT, TIM_CLK_EVENT,
                                       TIM_TMR_B_TO, TIM_CAP_B_MATCH, TIM_CAP_B_EVENT};

    tim_mask_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_event(src_event), .irq(irq));

    // free-running clock, 5 ns period
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // repeatable random source
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // only implemented enable bits survive
    function automatic logic [31:0] impl_bits(input logic [31:0] d);
        return d & {21'h000000, TIM_IMPL_MASK};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // sample pready only at rising edges, request held until then
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            tally_and_finish();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; src_event = 11'h000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TIM_OFS_MASK, 32'h0);
        chk("mask reset", rd, 32'h0);
        apb(1'b0, TIM_OFS_RAW, 32'h0);
        chk("raw reset", rd, 32'h0);
        apb(1'b1, TIM_OFS_MASK, 32'hFFFF_FFFF);
        apb(1'b0, TIM_OFS_MASK, 32'h0);
        chk("mask all ones", rd, 32'h0000_070F);
        apb(1'b1, 12'h100, 32'hFFFF_FFFF);
        chk("unmapped error", {31'h0, err}, 32'h1);
        for (int i = 0; i < 16; i++) begin
            // single enables first, then random masks and events
            m  = (i < 7) ? (32'h1 << pos[i]) : xorshift();
            ev = (i < 7) ? 11'h7FF : 11'(xorshift() & 32'h0000_07FF);
            apb(1'b1, TIM_OFS_MASK, m);
            apb(1'b0, TIM_OFS_MASK, 32'h0);
            chk("mask readback", rd, impl_bits(m));
            src_event <= ev;
            repeat (6) @(posedge pclk);
            apb(1'b0, TIM_OFS_RAW, 32'h0);
            chk("raw status", rd, impl_bits({21'h0, ev}));
            apb(1'b0, TIM_OFS_MSTAT, 32'h0);
            chk("masked status", rd, impl_bits({21'h0, ev}) & m);
            @(negedge pclk);
            chk("irq level", {31'h0, irq}, {31'h0, |(impl_bits({21'h0, ev}) & m)});
            src_event <= 11'h000;
            apb(1'b1, TIM_OFS_CLEAR, 32'h0000_07FF);
            repeat (2) @(negedge pclk);
            chk("irq after clear", {31'h0, irq}, 32'h0);
            apb(1'b0, TIM_OFS_RAW, 32'h0);
            chk("raw after clear", rd, 32'h0);
        end
        tally_and_finish();
    end
endmodule
